// >>> tpp_pkg.sv
// Constants, field layout and mode codes for the three-pin port with alternate mux
package tpp_pkg;

    localparam int          TPP_PIN_N      = 3;       // Number of port pins
    localparam int          TPP_ADDR_W     = 2;       // Register address width
    localparam int          TPP_DATA_W     = 8;       // Register data width

    // Register addresses
    localparam logic [1:0]  TPP_REG_CFG1   = 2'h0;    // Pull-up and direction
    localparam logic [1:0]  TPP_REG_CFG2   = 2'h1;    // PWM and serial routing
    localparam logic [1:0]  TPP_REG_DATA   = 2'h2;    // Port data

    // Field positions
    localparam int          TPP_DIR_LSB    = 0;       // Direction bits 2..0
    localparam int          TPP_PUE_LSB    = 4;       // Pull-up enable bits 6..4
    localparam int          TPP_MODE_LSB   = 0;       // Serial route mode 1..0
    localparam int          TPP_PWM_EN_BIT = 2;       // PWM route enable
    localparam int          TPP_PWM_SEL_BIT = 3;      // PWM channel select
    localparam int          TPP_DATA_LSB   = 0;       // Data bits 2..0

    // Pin indices
    localparam int          TPP_PIN0       = 0;
    localparam int          TPP_PIN1       = 1;
    localparam int          TPP_PIN2       = 2;

    // Reset values
    localparam logic [2:0]  TPP_RST_PINS   = 3'h0;    // Direction, pull-up, data
    localparam logic [3:0]  TPP_RST_CFG2   = 4'h0;    // Routing fields
    localparam logic [7:0]  TPP_RD_ZERO    = 8'h00;   // Idle or unmapped read data
    localparam logic        TPP_SER_IDLE   = 1'b1;    // Serial idle (recessive) level
    localparam logic        TPP_OE_OFF     = 1'b1;    // Output enable, not driving

    // Serial route modes
    typedef enum logic [1:0] {
        TPP_MODE_INTERNAL = 2'b00,                    // Serial to LIN layer inside
        TPP_MODE_EXT_SCI  = 2'b01,                    // Serial on pins 0 and 1
        TPP_MODE_EXT_LIN  = 2'b10,                    // LIN layer on pins 0 and 1
        TPP_MODE_OBSERVE  = 2'b11                     // Inside link, pins mirror it
    } tpp_mode_t;

endpackage

// >>> tpp_pin_if.sv
// Interface between the port core and its priority pin multiplexer
`timescale 1ns/1ps
`default_nettype none
interface tpp_pin_if;
    import tpp_pkg::*;
    logic [2:0] analog_sel;   // Analog input owns pin
    logic [2:0] timer_sel;    // Timer channel owns pin
    logic [2:0] timer_dir;    // Timer channel is output compare
    logic [2:0] timer_out;    // Timer compare levels
    logic [1:0] pwm_out;      // PWM channel levels
    logic       sci_txd;      // Serial transmit from serial unit
    logic       lin_rxd;      // Receive from LIN layer
    logic [2:0] dir;          // Direction bits
    logic [2:0] data;         // Port output register
    logic [2:0] pue;          // Pull-up enables
    logic       pwm_sel;      // PWM channel select
    logic       pwm_en;       // PWM route enable
    tpp_mode_t  mode;         // Serial route mode
    logic [2:0] pin_sync;     // Synchronised pin levels
    logic [2:0] drv_en;       // Resolved drive enable, active high
    logic [2:0] drv_val;      // Resolved drive level
    logic [2:0] pull;         // Resolved pull-up
    logic       sci_rxd;      // Receive to serial unit
    logic       lin_txd;      // Transmit to LIN layer

    modport core (
        output analog_sel, timer_sel, timer_dir, timer_out, pwm_out, sci_txd, lin_rxd,
        output dir, data, pue, pwm_sel, pwm_en, mode, pin_sync,
        input  drv_en, drv_val, pull, sci_rxd, lin_txd
    );
    modport mux (
        input  analog_sel, timer_sel, timer_dir, timer_out, pwm_out, sci_txd, lin_rxd,
        input  dir, data, pue, pwm_sel, pwm_en, mode, pin_sync,
        output drv_en, drv_val, pull, sci_rxd, lin_txd
    );
endinterface
`default_nettype wire

// >>> tpp_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module tpp_sync
    import tpp_pkg::*;
#(
    parameter int WIDTH = TPP_PIN_N
)(
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;     // First stage, read only by second
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;     // Second stage, safe to use
    logic [WIDTH-1:0] sync_nxt;

    // Next values of both stages
    always_comb
    begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // Stages clear to zero under reset
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule
`default_nettype wire

// >>> tpp_mux.sv
// Fixed-priority alternate function multiplexer for the three pins
`timescale 1ns/1ps
`default_nettype none
module tpp_mux
    import tpp_pkg::*;
(
    tpp_pin_if.mux pif
);
    logic [2:0] ser_own;   // Serial or PWM level claims the pin
    logic [2:0] ser_en;    // Serial or PWM level drives the pin
    logic [2:0] ser_val;   // Serial or PWM drive level

    // Serial routing and PWM pick for the third level
    always_comb
    begin
        ser_own          = '0;
        ser_en           = '0;
        ser_val          = '0;
        pif.sci_rxd      = TPP_SER_IDLE;
        pif.lin_txd      = TPP_SER_IDLE;
        unique case (pif.mode)
            TPP_MODE_INTERNAL:
            begin
                // Link stays inside, pins left to plain I/O
                pif.sci_rxd = pif.lin_rxd;
                pif.lin_txd = pif.sci_txd;
            end
            TPP_MODE_EXT_SCI:
            begin
                // Pin 0 receives, pin 1 transmits for the serial unit
                ser_own[TPP_PIN1:TPP_PIN0] = 2'h3;
                pif.sci_rxd       = pif.pin_sync[TPP_PIN0];
                ser_en[TPP_PIN1]  = 1'b1;
                ser_val[TPP_PIN1] = pif.sci_txd;
            end
            TPP_MODE_EXT_LIN:
            begin
                // LIN layer receive leaves on pin 0, its transmit comes in on pin 1
                ser_own[TPP_PIN1:TPP_PIN0] = 2'h3;
                ser_en[TPP_PIN0]  = 1'b1;
                ser_val[TPP_PIN0] = pif.lin_rxd;
                pif.lin_txd       = pif.pin_sync[TPP_PIN1];
            end
            TPP_MODE_OBSERVE:
            begin
                // Link kept inside, both pins mirror it as outputs
                pif.sci_rxd       = pif.lin_rxd;
                pif.lin_txd       = pif.sci_txd;
                ser_own[TPP_PIN1:TPP_PIN0] = 2'h3;
                ser_en[TPP_PIN1:TPP_PIN0]  = 2'h3;
                ser_val[TPP_PIN0] = pif.lin_rxd;
                ser_val[TPP_PIN1] = pif.sci_txd;
            end
        endcase
        // Pin 2 carries the chosen PWM channel only while enabled
        ser_own[TPP_PIN2] = pif.pwm_en;
        ser_en[TPP_PIN2]  = pif.pwm_en;
        ser_val[TPP_PIN2] = pif.pwm_sel ? pif.pwm_out[1] : pif.pwm_out[0];
    end

    // Per-pin ranking: analog, timer, serial or PWM, plain I/O
    genvar gi;
    generate
        for (gi = 0; gi < TPP_PIN_N; gi++)
        begin : g_pin
            assign pif.drv_en[gi]  = pif.analog_sel[gi] ? 1'b0 :
                                     pif.timer_sel[gi]  ? pif.timer_dir[gi] :
                                     ser_own[gi]        ? ser_en[gi] :
                                     pif.dir[gi];
            assign pif.drv_val[gi] = pif.analog_sel[gi] ? 1'b0 :
                                     pif.timer_sel[gi]  ? pif.timer_out[gi] :
                                     ser_own[gi]        ? ser_val[gi] :
                                     pif.data[gi];
            // Pull-up never fights a driven or analog pin
            assign pif.pull[gi]    = pif.pue[gi] & ~pif.dir[gi]
                                     & ~pif.drv_en[gi] & ~pif.analog_sel[gi];
        end
    endgenerate
endmodule
`default_nettype wire

// >>> tpp_port.sv
// Top of the three-pin port: registers, synchroniser, pin mux and output stage
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tpp_port
    import tpp_pkg::*;
#(
    parameter int ADDR_W = TPP_ADDR_W
)(
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // Requests from the modules owning alternate functions
    input  wire logic [2:0]        analog_in_sel,
    input  wire logic [2:0]        timer_chan_sel,
    input  wire logic [2:0]        timer_chan_dir,
    input  wire logic [2:0]        timer_chan_out,
    output logic      [2:0]        timer_chan_in,
    input  wire logic [1:0]        pwm_chan_out,
    input  wire logic              sci_txd,
    output logic                   sci_rxd,
    input  wire logic              lin_rxd,
    output logic                   lin_txd,
    // Pads
    input  wire logic [2:0]        pad_in,
    output logic      [2:0]        pad_out,
    output logic      [2:0]        pad_oe_n,
    output logic      [2:0]        pad_pullup_en
);

    tpp_pin_if   pif ();                 // Core to mux bundle

    // Software registers
    logic [2:0]  pin_direction_bits_r;   // One bit per pin, set means output
    logic [2:0]  pin_direction_bits_nxt;
    logic [2:0]  pullup_enable_r;        // One bit per pin, set enables pull-up
    logic [2:0]  pullup_enable_nxt;
    logic        pwm_channel_select_r;   // Clear picks channel 0
    logic        pwm_channel_select_nxt;
    logic        pwm_route_enable_r;     // Set drives PWM on pin 2
    logic        pwm_route_enable_nxt;
    tpp_mode_t   serial_route_mode_r;    // How serial and LIN reach pins
    tpp_mode_t   serial_route_mode_nxt;
    logic [2:0]  port_data_r;            // Port output register
    logic [2:0]  port_data_nxt;
    logic [7:0]  rdata_r;                // Read data, valid one cycle
    logic [7:0]  rdata_nxt;

    // Registered outputs
    logic [2:0]  pad_out_r;
    logic [2:0]  pad_out_nxt;
    logic [2:0]  pad_oe_n_r;
    logic [2:0]  pad_oe_n_nxt;
    logic [2:0]  pull_r;
    logic [2:0]  pull_nxt;
    logic        sci_rxd_r;
    logic        sci_rxd_nxt;
    logic        lin_txd_r;
    logic        lin_txd_nxt;

    logic [2:0]  pin_sync;               // Pin levels on the bus clock
    logic [7:0]  cfg1_view;              // Read image of first config register
    logic [7:0]  cfg2_view;              // Read image of second config register
    logic [7:0]  data_view;              // Read image of data register
    logic [2:0]  data_read_bits;         // Per-pin data read value

    // Pads are asynchronous, so every read path goes through two flops
    tpp_sync #(
        .WIDTH    (TPP_PIN_N)
    ) u_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .async_in (pad_in),
        .sync_out (pin_sync)
    );

    // Feed the mux; analog and timer selects come only from the owning modules, serial and PWM routes from registers
    assign pif.analog_sel = analog_in_sel;
    assign pif.timer_sel  = timer_chan_sel;
    assign pif.timer_dir  = timer_chan_dir;
    assign pif.timer_out  = timer_chan_out;
    assign pif.pwm_out    = pwm_chan_out;
    assign pif.sci_txd    = sci_txd;
    assign pif.lin_rxd    = lin_rxd;
    assign pif.dir        = pin_direction_bits_r;
    assign pif.data       = port_data_r;
    assign pif.pue        = pullup_enable_r;
    assign pif.pwm_sel    = pwm_channel_select_r;
    assign pif.pwm_en     = pwm_route_enable_r;
    assign pif.mode       = serial_route_mode_r;
    assign pif.pin_sync   = pin_sync;

    tpp_mux u_mux (
        .pif (pif.mux)
    );

    // Read images, unused bits read as zero
    always_comb
    begin
        cfg1_view = TPP_RD_ZERO;
        cfg1_view[TPP_DIR_LSB +: TPP_PIN_N] = pin_direction_bits_r;
        cfg1_view[TPP_PUE_LSB +: TPP_PIN_N] = pullup_enable_r;
        cfg2_view = TPP_RD_ZERO;
        cfg2_view[TPP_MODE_LSB +: 2]   = serial_route_mode_r;
        cfg2_view[TPP_PWM_EN_BIT]      = pwm_route_enable_r;
        cfg2_view[TPP_PWM_SEL_BIT]     = pwm_channel_select_r;
        // Output pins echo the register, inputs show the synced pad
        data_read_bits = (pin_direction_bits_r & port_data_r)
                       | (~pin_direction_bits_r & pin_sync);
        data_view = TPP_RD_ZERO;
        data_view[TPP_DATA_LSB +: TPP_PIN_N] = data_read_bits;
    end

    // Register writes and read answer
    always_comb
    begin
        pin_direction_bits_nxt = pin_direction_bits_r;
        pullup_enable_nxt      = pullup_enable_r;
        pwm_channel_select_nxt = pwm_channel_select_r;
        pwm_route_enable_nxt   = pwm_route_enable_r;
        serial_route_mode_nxt  = serial_route_mode_r;
        port_data_nxt          = port_data_r;
        rdata_nxt              = TPP_RD_ZERO;
        if (reg_wr)
        begin
            // Unmapped writes fall through and change nothing
            if (reg_addr == TPP_REG_CFG1)
            begin
                pin_direction_bits_nxt = reg_wdata[TPP_DIR_LSB +: TPP_PIN_N];
                pullup_enable_nxt      = reg_wdata[TPP_PUE_LSB +: TPP_PIN_N];
            end
            else if (reg_addr == TPP_REG_CFG2)
            begin
                pwm_channel_select_nxt = reg_wdata[TPP_PWM_SEL_BIT];
                pwm_route_enable_nxt   = reg_wdata[TPP_PWM_EN_BIT];
                serial_route_mode_nxt  = tpp_mode_t'(reg_wdata[TPP_MODE_LSB +: 2]);
            end
            else if (reg_addr == TPP_REG_DATA)
            begin
                // Stored even on input pins, shows once the pin turns output
                port_data_nxt = reg_wdata[TPP_DATA_LSB +: TPP_PIN_N];
            end
        end
        if (reg_rd)
        begin
            if (reg_addr == TPP_REG_CFG1)
            begin
                rdata_nxt = cfg1_view;
            end
            else if (reg_addr == TPP_REG_CFG2)
            begin
                rdata_nxt = cfg2_view;
            end
            else if (reg_addr == TPP_REG_DATA)
            begin
                rdata_nxt = data_view;
            end
        end
    end

    // Output stage next values, registered to keep pads glitch free
    always_comb
    begin
        pad_out_nxt  = pif.drv_val;
        pad_oe_n_nxt = ~pif.drv_en;
        pull_nxt     = pif.pull;
        sci_rxd_nxt  = pif.sci_rxd;
        lin_txd_nxt  = pif.lin_txd;
    end

    // All state flops
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_direction_bits_r <= TPP_RST_PINS;
            pullup_enable_r      <= TPP_RST_PINS;
            pwm_channel_select_r <= TPP_RST_CFG2[TPP_PWM_SEL_BIT];
            pwm_route_enable_r   <= TPP_RST_CFG2[TPP_PWM_EN_BIT];
            serial_route_mode_r  <= TPP_MODE_INTERNAL;
            port_data_r          <= TPP_RST_PINS;
            rdata_r              <= TPP_RD_ZERO;
            pad_out_r            <= TPP_RST_PINS;
            pad_oe_n_r           <= {TPP_PIN_N{TPP_OE_OFF}};
            pull_r               <= TPP_RST_PINS;
            sci_rxd_r            <= TPP_SER_IDLE;
            lin_txd_r            <= TPP_SER_IDLE;
        end
        else
        begin
            pin_direction_bits_r <= pin_direction_bits_nxt;
            pullup_enable_r      <= pullup_enable_nxt;
            pwm_channel_select_r <= pwm_channel_select_nxt;
            pwm_route_enable_r   <= pwm_route_enable_nxt;
            serial_route_mode_r  <= serial_route_mode_nxt;
            port_data_r          <= port_data_nxt;
            rdata_r              <= rdata_nxt;
            pad_out_r            <= pad_out_nxt;
            pad_oe_n_r           <= pad_oe_n_nxt;
            pull_r               <= pull_nxt;
            sci_rxd_r            <= sci_rxd_nxt;
            lin_txd_r            <= lin_txd_nxt;
        end
    end

    assign reg_rdata     = rdata_r;
    assign pad_out       = pad_out_r;
    assign pad_oe_n      = pad_oe_n_r;
    assign pad_pullup_en = pull_r;
    assign sci_rxd       = sci_rxd_r;
    assign lin_txd       = lin_txd_r;
    assign timer_chan_in = pin_sync;     // Capture inputs see synced pads

    // Checks on the observable pin and register behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_analog_wins: assert property (
        analog_in_sel[TPP_PIN0] |=> pad_oe_n[TPP_PIN0] && !pad_pullup_en[TPP_PIN0])
        else $error("analog pin still driven or pulled");

    chk_timer_pin_one: assert property (
        (!analog_in_sel[TPP_PIN1] && timer_chan_sel[TPP_PIN1] && timer_chan_dir[TPP_PIN1])
        |=> !pad_oe_n[TPP_PIN1] && pad_out[TPP_PIN1] == $past(timer_chan_out[TPP_PIN1]))
        else $error("timer channel one not on pin one");

    chk_pwm_route: assert property (
        (!analog_in_sel[TPP_PIN2] && !timer_chan_sel[TPP_PIN2] && pwm_route_enable_r)
        |=> !pad_oe_n[TPP_PIN2]
            && pad_out[TPP_PIN2] == $past(pwm_chan_out[pwm_channel_select_r]))
        else $error("selected pwm channel not on pin two");

    chk_pwm_off_gpio: assert property (
        (!analog_in_sel[TPP_PIN2] && !timer_chan_sel[TPP_PIN2] && !pwm_route_enable_r)
        |=> pad_oe_n[TPP_PIN2] == !$past(pin_direction_bits_r[TPP_PIN2])
            && (pad_oe_n[TPP_PIN2] || pad_out[TPP_PIN2] == $past(port_data_r[TPP_PIN2])))
        else $error("pin two not plain io with pwm off");

    chk_mode_internal: assert property (
        (serial_route_mode_r == TPP_MODE_INTERNAL)
        |=> sci_rxd == $past(lin_rxd) && lin_txd == $past(sci_txd))
        else $error("internal link broken in mode zero");

    chk_mode_ext_sci: assert property (
        (serial_route_mode_r == TPP_MODE_EXT_SCI && analog_in_sel[TPP_PIN1:TPP_PIN0] == 2'h0
         && timer_chan_sel[TPP_PIN1:TPP_PIN0] == 2'h0)
        |=> sci_rxd == $past(pin_sync[TPP_PIN0]) && pad_oe_n[TPP_PIN1:TPP_PIN0] == 2'h1
            && pad_out[TPP_PIN1] == $past(sci_txd))
        else $error("serial unit not on pins in mode one");

    chk_mode_ext_lin: assert property (
        (serial_route_mode_r == TPP_MODE_EXT_LIN && analog_in_sel[TPP_PIN1:TPP_PIN0] == 2'h0
         && timer_chan_sel[TPP_PIN1:TPP_PIN0] == 2'h0)
        |=> lin_txd == $past(pin_sync[TPP_PIN1]) && pad_oe_n[TPP_PIN1:TPP_PIN0] == 2'h2
            && pad_out[TPP_PIN0] == $past(lin_rxd) && sci_rxd)
        else $error("lin layer not on pins in mode two");

    chk_mode_observe: assert property (
        (serial_route_mode_r == TPP_MODE_OBSERVE && analog_in_sel[TPP_PIN1:TPP_PIN0] == 2'h0
         && timer_chan_sel[TPP_PIN1:TPP_PIN0] == 2'h0)
        |=> pad_oe_n[TPP_PIN1:TPP_PIN0] == 2'h0 && sci_rxd == $past(lin_rxd)
            && pad_out[TPP_PIN1] == $past(sci_txd))
        else $error("observe mode does not mirror the link");

    chk_pullup_output: assert property (
        pin_direction_bits_r[TPP_PIN0] |=> !pad_pullup_en[TPP_PIN0])
        else $error("pull-up active on output pin");

    chk_pullup_enable: assert property (
        (pullup_enable_r[TPP_PIN1] && !pin_direction_bits_r[TPP_PIN1]
         && !analog_in_sel[TPP_PIN1] && !timer_chan_sel[TPP_PIN1]
         && serial_route_mode_r == TPP_MODE_INTERNAL)
        |=> pad_pullup_en[TPP_PIN1])
        else $error("enabled pull-up not applied");

    chk_read_output: assert property (
        (reg_rd && reg_addr == TPP_REG_DATA && pin_direction_bits_r[TPP_PIN0])
        |=> reg_rdata[TPP_PIN0] == $past(port_data_r[TPP_PIN0]))
        else $error("data read of output pin not register");

    chk_read_sync_delay: assert property (
        (reg_rd && reg_addr == TPP_REG_DATA && !pin_direction_bits_r[TPP_PIN1])
        |=> reg_rdata[TPP_PIN1] == $past(pad_in[TPP_PIN1], 3))
        else $error("input read not two flops behind pad");

    chk_read_one_cycle: assert property (
        !reg_rd |=> reg_rdata == TPP_RD_ZERO)
        else $error("read data held past its cycle");

endmodule
`default_nettype wire

// >>> tpp_board.sv
// Board model: pads driven by the port, an external source or a pull-up
`timescale 1ns/1ps
`default_nettype none
module tpp_board (
    input  wire logic [2:0] pad_out,
    input  wire logic [2:0] pad_oe_n,
    input  wire logic [2:0] pad_pullup_en,
    input  wire logic [2:0] ext_en,
    input  wire logic [2:0] ext_val,
    output logic      [2:0] pad_in
);
    // Port drive wins; a floating pad shows the inverse of pad_out, so it never reads back as the port's own level
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                        pad_pullup_en[i] ? 1'b1 : ~pad_out[i];
    end
endmodule
`default_nettype wire

// >>> testbench.sv
// Register-level bench for the three-pin port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tpp_pkg::*;
    logic       clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0] reg_addr = 2'h0, pwm_chan_out = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [2:0] analog_in_sel = 3'h0, timer_chan_sel = 3'h0, timer_chan_dir = 3'h0;
    logic [2:0] timer_chan_out = 3'h0, timer_chan_in, pad_in, pad_out, pad_oe_n;
    logic [2:0] pad_pullup_en, ext_en = 3'h3, ext_val = 3'h0;
    logic       sci_txd = 1'b0, lin_rxd = 1'b1, sci_rxd, lin_txd;
    int         error_cnt = 0, num_checks = 0;
    logic [5:0] mode_exp [4] = '{6'h2A, 6'h15, 6'h2F, 6'h09};
    logic [7:0] pwm_cfg [3] = '{8'h00, 8'h04, 8'h0C};
    always #4 clk_sys = ~clk_sys;
    tpp_port u_dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .analog_in_sel, .timer_chan_sel, .timer_chan_dir, .timer_chan_out, .timer_chan_in,
        .pwm_chan_out, .sci_txd, .sci_rxd, .lin_rxd, .lin_txd, .pad_in, .pad_out, .pad_oe_n,
        .pad_pullup_en);
    tpp_board u_board (.pad_out, .pad_oe_n, .pad_pullup_en, .ext_en, .ext_val, .pad_in);
    // Compare and count
    task automatic ck(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read strobe, data checked in the following cycle only
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 ck(reg_rdata, exp);
    endtask
    // Covers output flop plus the two-stage synchroniser
    task automatic settle;
        repeat (5) @(posedge clk_sys);
        #1;
    endtask
    task automatic summarize;
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard, far beyond the roughly 113 cycles the tests need
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        summarize;
    end
    initial
    begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(TPP_REG_CFG1, 8'h00);
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00);
        rd(TPP_REG_CFG2, 8'h00);
        wr(TPP_REG_CFG1, 8'hFD);
        rd(TPP_REG_CFG1, 8'h75);
        wr(TPP_REG_DATA, 8'hFF);
        settle;
        ck(pad_oe_n, 3'h2);
        ck(pad_pullup_en, 3'h2);
        rd(TPP_REG_DATA, 8'h05);
        ext_val <= 3'h2;
        settle;
        rd(TPP_REG_DATA, 8'h07);
        // Every serial route mode, pins 0 and 1 plus both internal links
        wr(TPP_REG_DATA, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            wr(TPP_REG_CFG2, 8'(m));
            settle;
            ck({pad_oe_n[1:0], sci_rxd, lin_txd, pad_out[1:0] | pad_oe_n[1:0]}, mode_exp[m]);
        end
        // Pin 2: plain data 0, then channel 0 at 1, channel 1 at 0
        wr(TPP_REG_DATA, 8'h00);
        pwm_chan_out <= 2'h1;
        for (int k = 0; k < 3; k++)
        begin
            wr(TPP_REG_CFG2, pwm_cfg[k]);
            settle;
            ck(pad_out[2], 8'(k == 1));
        end
        // Timer owns pins 1 and 2, beating plain I/O and the enabled PWM
        @(posedge clk_sys);
        timer_chan_sel <= 3'h6;
        timer_chan_dir <= 3'h6;
        timer_chan_out <= 3'h6;
        settle;
        ck({pad_oe_n[2], pad_out[2], timer_chan_in[1], pad_oe_n[1], pad_out[1]}, 5'h0D);
        // Analog takes pins 0 and 2 away from driving and pull-up
        @(posedge clk_sys);
        analog_in_sel <= 3'h5;
        settle;
        ck({pad_oe_n[2], pad_pullup_en[2], pad_oe_n[0], pad_pullup_en[0]}, 4'hA);
        summarize;
    end
endmodule
`default_nettype wire
